// ===== core/swsp_slot_timer.sv
// Single-wire slot timing and pullup engine with an Avalon-MM register port.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`default_nettype none
module swsp_slot_timer #(
    parameter int TW = swsp_pkg::TW,
    parameter swsp_pkg::swsp_tab_t DEF_CYC = swsp_pkg::DEF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe,
    input wire logic apuThrIn,
    output logic apuOe,
    output logic weakPuOn
);
    localparam int CW = TW + 2;
    localparam int NTAB = swsp_pkg::NTAB;

    typedef struct packed {
        swsp_pkg::swsp_state_e st;
        swsp_pkg::swsp_op_e op;
        logic bitv;
        logic speed;
        logic armed;
        logic apuOn;
        logic spuPend;
        logic spuOn;
        logic hiSeen;
        logic loSeen;
        logic short;
        logic rbit;
        logic pres;
        logic rdDone;
        logic drvLow;
        logic prevThr;
        logic [CW-1:0] cnt;
        logic [TW-1:0] recCnt;
        logic [swsp_pkg::CTRL_W-1:0] ctrl;
        logic [31:0] rdata;
        logic [NTAB-1:0][TW-1:0] tim;
    } swsp_q_s;

    swsp_q_s q;
    swsp_q_s d;
    logic [1:0] syncIn;
    logic lineHi;
    logic thrRise;
    logic cmdWr;
    logic ctrlWr;
    logic startCmd;
    logic trig;
    logic [TW-1:0] lowLen;
    logic [TW-1:0] recLen;
    logic [CW-1:0] lowEnd;
    logic [5:0] tIdx;

    ////////////////////////////////////////////////////////////////////////////////
    // Line input synchronisation.
    swsp_sync #(.W(2)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({apuThrIn, lineIn}),
        .syncOut(syncIn)
    );
    assign lineHi = syncIn[0];
    assign thrRise = syncIn[1] & ~q.prevThr;

    // Picks a period from the set of the current speed.
    function automatic logic [TW-1:0] tget(input logic [NTAB-1:0][TW-1:0] t, input logic sp, input int idx);
        return t[(sp ? swsp_pkg::NT : 0) + idx];
    endfunction : tget

    // True when a word address falls inside the timer table.
    function automatic logic isTime(input logic [7:0] a);
        return a[7:2] >= swsp_pkg::A_TIME_W && a[7:2] < swsp_pkg::A_TIME_W + 6'(NTAB);
    endfunction : isTime

    function automatic logic [CW-1:0] ext(input logic [TW-1:0] v);
        return {2'b00, v};
    endfunction : ext

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        d = q;
        d.prevThr = syncIn[1];
        tIdx = avs_address[7:2] - swsp_pkg::A_TIME_W;
        cmdWr = avs_write && avs_address == swsp_pkg::A_CMD && avs_byteenable[0];
        ctrlWr = avs_write && avs_address == swsp_pkg::A_CTRL && avs_byteenable[0];
        startCmd = cmdWr && q.st == swsp_pkg::S_IDLE && avs_writedata[swsp_pkg::K_OP +: 2] != 2'h3;
        avs_waitrequest = (avs_read && !q.rdDone) || (cmdWr && q.st != swsp_pkg::S_IDLE);
        lowLen = (q.op == swsp_pkg::OP_RST) ? tget(q.tim, q.speed, swsp_pkg::T_RSTL) :
                 (q.op == swsp_pkg::OP_WRITE && !q.bitv) ? tget(q.tim, q.speed, swsp_pkg::T_W0L) :
                 tget(q.tim, q.speed, swsp_pkg::T_W1L);
        recLen = TW'(tget(q.tim, q.speed, swsp_pkg::T_REC)
                 + ((q.op == swsp_pkg::OP_WRITE && !q.bitv) ? TW'(0) :
                    TW'(tget(q.tim, q.speed, swsp_pkg::T_W0L) - tget(q.tim, q.speed, swsp_pkg::T_W1L)))
                 + (q.ctrl[swsp_pkg::C_MULTI] ? tget(q.tim, q.speed, swsp_pkg::T_RECX) : TW'(0)));
        lowEnd = ext(lowLen);
        trig = q.armed && thrRise && (q.st != swsp_pkg::S_RHI || q.loSeen);

        // Register port.
        d.rdDone = avs_read && !q.rdDone;
        if (avs_read && !q.rdDone) begin
            if (avs_address == swsp_pkg::A_CTRL) begin
                d.rdata = {28'h0000000, q.ctrl};
            end else if (avs_address == swsp_pkg::A_STAT) begin
                d.rdata = {26'h0000000, q.apuOn, q.short, q.spuOn, q.pres, q.rbit, q.st != swsp_pkg::S_IDLE};
            end else if (isTime(avs_address)) begin
                d.rdata = {16'h0000, q.tim[tIdx]};
            end else begin
                d.rdata = 32'h00000000;
            end
        end
        if (ctrlWr) begin
            d.ctrl = avs_writedata[swsp_pkg::CTRL_W-1:0];
            if (!avs_writedata[swsp_pkg::C_SPU]) begin
                d.spuOn = 1'b0;
                d.spuPend = 1'b0;
            end
        end
        if (avs_write && isTime(avs_address) && avs_byteenable[1:0] == 2'h3) begin
            d.tim[tIdx] = avs_writedata[TW-1:0];
        end

        // Slot sequencer.
        case (q.st)
            swsp_pkg::S_IDLE: begin
                if (startCmd) begin
                    d.st = swsp_pkg::S_LOW;
                    d.op = swsp_pkg::swsp_op_e'(avs_writedata[swsp_pkg::K_OP +: 2]);
                    d.bitv = avs_writedata[swsp_pkg::K_BIT];
                    d.speed = q.ctrl[swsp_pkg::C_OD];
                    d.cnt = '0;
                    d.drvLow = 1'b1;
                    d.armed = 1'b0;
                    d.hiSeen = 1'b0;
                    d.loSeen = 1'b0;
                    d.short = 1'b0;
                    d.pres = 1'b0;
                    if (q.spuOn) begin
                        d.spuOn = 1'b0;
                        d.spuPend = 1'b0;
                        d.ctrl[swsp_pkg::C_SPU] = 1'b0;
                    end else begin
                        d.spuPend = q.ctrl[swsp_pkg::C_SPU];
                    end
                end
            end
            swsp_pkg::S_LOW: begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt + 1'b1 >= lowEnd) begin
                    d.drvLow = 1'b0;
                    d.armed = 1'b1;
                    d.st = (q.op == swsp_pkg::OP_RST) ? swsp_pkg::S_ACTIVE_PULLUP_IMPEDANCE : swsp_pkg::S_REL;
                end
            end
            swsp_pkg::S_REL: begin
                d.cnt = q.cnt + 1'b1;
                if (lineHi) begin
                    d.st = swsp_pkg::S_REC;
                    d.recCnt = '0;
                end else if (q.cnt >= lowEnd + ext(tget(q.tim, q.speed, swsp_pkg::T_RSTH))) begin
                    d.short = 1'b1;
                    d.armed = 1'b0;
                    d.apuOn = 1'b0;
                    d.st = swsp_pkg::S_IDLE;
                end
            end
            swsp_pkg::S_REC: begin
                d.cnt = q.cnt + 1'b1;
                d.recCnt = q.recCnt + 1'b1;
                if (q.recCnt + 1'b1 >= recLen && (q.op != swsp_pkg::OP_READ ||
                    q.cnt + 1'b1 >= ext(tget(q.tim, q.speed, swsp_pkg::T_SLOT)))) begin
                    d.st = swsp_pkg::S_IDLE;
                    d.apuOn = 1'b0;
                    d.armed = 1'b0;
                end
            end
            swsp_pkg::S_ACTIVE_PULLUP_IMPEDANCE: begin
                d.cnt = q.cnt + 1'b1;
                if (lineHi) begin
                    d.hiSeen = 1'b1;
                end
                if (q.cnt + 1'b1 >= lowEnd + ext(tget(q.tim, q.speed, swsp_pkg::T_APU))) begin
                    d.apuOn = 1'b0;
                    d.armed = 1'b1;
                    d.st = swsp_pkg::S_RHI;
                end
            end
            swsp_pkg::S_RHI: begin
                d.cnt = q.cnt + 1'b1;
                if (lineHi) begin
                    d.hiSeen = 1'b1;
                end else if (q.hiSeen) begin
                    d.loSeen = 1'b1;
                    d.pres = 1'b1;
                end
                if (q.cnt + 1'b1 >= lowEnd + ext(tget(q.tim, q.speed, swsp_pkg::T_RSTH))) begin
                    d.st = swsp_pkg::S_IDLE;
                    d.apuOn = 1'b0;
                    d.armed = 1'b0;
                    d.short = !q.hiSeen && !lineHi;
                end
            end
            default: begin
                d.st = swsp_pkg::S_IDLE;
            end
        endcase

        // Read sample at the sample point of a read slot.
        if (q.op == swsp_pkg::OP_READ && q.st != swsp_pkg::S_IDLE &&
            q.cnt == ext(tget(q.tim, q.speed, swsp_pkg::T_MSR))) begin
            d.rbit = lineHi;
        end
        // Trigger fires only inside a slot or reset cycle; a set here wins over a clear above, except apuOn when the sequencer returns to S_IDLE.
        if (trig && q.st != swsp_pkg::S_IDLE) begin
            d.armed = 1'b0;
            if (d.st != swsp_pkg::S_IDLE) begin
                d.apuOn = q.ctrl[swsp_pkg::C_APU];
            end
            if (q.spuPend) begin
                d.spuOn = 1'b1;
                d.spuPend = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.prevThr <= 1'b1;
            for (int i = 0; i < NTAB; i++) begin
                q.tim[i] <= TW'(DEF_CYC[i]);
            end
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.rdata;
    assign lineOut = 1'b0;
    assign lineOe = q.drvLow;
    assign weakPuOn = !q.drvLow;
    assign apuOe = q.apuOn | q.spuOn;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sSpuEngage;
        q.spuPend && trig && q.st != swsp_pkg::S_IDLE && !ctrlWr;
    endsequence
    AST_FALL_BY_CMD: assert property ($rose(q.drvLow) |-> $past(startCmd))
        else $error("Line driven low without a command.");
    AST_W1_RELEASE: assert property ($fell(q.drvLow) && q.op != swsp_pkg::OP_RST && q.bitv
        |-> $past(q.cnt) + 1'b1 == $past(lowEnd))
        else $error("Write-one low period length wrong.");
    AST_W0_HOLD: assert property ($fell(q.drvLow) && q.op == swsp_pkg::OP_WRITE && !q.bitv
        |-> $past(q.cnt) + 1'b1 >= ext(tget(q.tim, q.speed, swsp_pkg::T_W0L)))
        else $error("Write-zero released too early.");
    AST_REC_DONE: assert property ($changed(q.st) && q.st == swsp_pkg::S_IDLE && $past(q.st) == swsp_pkg::S_REC
        |-> $past(q.recCnt) + 1'b1 >= $past(recLen))
        else $error("Recovery interval cut short.");
    AST_READ_SLOT: assert property ($past(q.st) == swsp_pkg::S_REC && q.st == swsp_pkg::S_IDLE
        && q.op == swsp_pkg::OP_READ |-> $past(q.cnt) + 1'b1 >= ext(tget(q.tim, q.speed, swsp_pkg::T_SLOT)))
        else $error("Read slot ended before slot duration.");
    AST_APU_CAUSE: assert property ($rose(q.apuOn) |-> $past(q.armed) && $past(thrRise)
        && $past(q.st) != swsp_pkg::S_IDLE)
        else $error("Active pullup without an armed trigger.");
    AST_SPU_ENGAGE: assert property (sSpuEngage |=> q.spuOn [*2])
        else $error("Strong pullup did not engage and hold.");
    AST_SPU_HOLD: assert property (q.spuOn && !startCmd && !ctrlWr |=> q.spuOn)
        else $error("Strong pullup dropped without cause.");
    AST_SPU_AUTOCLR: assert property ($fell(q.spuOn) |-> !q.ctrl[swsp_pkg::C_SPU])
        else $error("Strong pullup enable not cleared.");
    AST_APU_CFG: assert property (q.spuOn && !ctrlWr |=> $stable(q.ctrl[swsp_pkg::C_APU]))
        else $error("Active pullup setting changed by strong pullup.");
    AST_IDLE_QUIET: assert property (q.st == swsp_pkg::S_IDLE && !startCmd |=> !q.apuOn && !q.drvLow)
        else $error("Pullup or drive outside a slot.");
    AST_RST_APU_END: assert property ($past(q.st) == swsp_pkg::S_ACTIVE_PULLUP_IMPEDANCE && q.st == swsp_pkg::S_RHI
        |-> !q.apuOn && q.armed)
        else $error("Reset pullup interval handling wrong.");
endmodule : swsp_slot_timer
`default_nettype wire

// ===== common/swsp_pkg.sv
// Shared constants and types for the single-wire slot and pullup timer.
`default_nettype none
package swsp_pkg;
    localparam int CLK_NS = 10;
    localparam int TW = 16;
    localparam int CW = TW + 2;
    localparam int NT = 9;
    localparam int NTAB = 2 * NT;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [5:0] A_TIME_W = 6'h10;
    localparam int C_OD = 0;
    localparam int C_APU = 1;
    localparam int C_SPU = 2;
    localparam int C_MULTI = 3;
    localparam int CTRL_W = 4;
    localparam int K_OP = 0;
    localparam int K_BIT = 2;
    localparam int S_BUSY = 0;
    localparam int S_RBIT = 1;
    localparam int S_PRES = 2;
    localparam int S_SPU = 3;
    localparam int S_SHORT = 4;
    localparam int S_APU = 5;
    localparam int T_W1L = 0;
    localparam int T_W0L = 1;
    localparam int T_REC = 2;
    localparam int T_MSR = 3;
    localparam int T_SLOT = 4;
    localparam int T_RSTL = 5;
    localparam int T_RSTH = 6;
    localparam int T_APU = 7;
    localparam int T_RECX = 8;
    typedef int unsigned swsp_tab_t [NTAB];
    // Standard speed first, then overdrive, in ns.
    localparam swsp_tab_t DEF_NS = '{8000, 60000, 5000, 14000, 70000, 560000, 560000, 1000, 5000,
                                    1000, 8000, 2000, 2000, 10000, 56000, 56000, 500, 2000};
    typedef enum logic [2:0] {S_IDLE, S_LOW, S_REL, S_REC, S_ACTIVE_PULLUP_IMPEDANCE, S_RHI} swsp_state_e;
    typedef enum logic [1:0] {OP_RST, OP_WRITE, OP_READ} swsp_op_e;
    function automatic swsp_tab_t defCyc();
        swsp_tab_t t;
        for (int i = 0; i < NTAB; i++) begin
            t[i] = (DEF_NS[i] + CLK_NS - 1) / CLK_NS;
        end
        return t;
    endfunction : defCyc
    localparam swsp_tab_t DEF_CYC = defCyc();
endpackage : swsp_pkg
`default_nettype wire

// ===== core/swsp_sync.sv
// Two-stage synchroniser for asynchronous line inputs.
`default_nettype none
module swsp_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : gBit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= asyncIn[g];
                    sync_q <= meta_q;
                end
            end
            assign syncOut[g] = sync_q;
        end
    endgenerate
endmodule : swsp_sync
`default_nettype wire

// ===== verification/swsp_slave_model.sv
// Behavioural slave device on the shared open-drain line.
`default_nettype none
module swsp_slave_model (
    input wire logic clk,
    input wire logic lineLevel,
    input wire logic presEn,
    input wire logic readZero,
    input wire logic forceLow,
    input wire logic [7:0] holdCyc,
    output logic slvLow
);
    timeunit 1ns;
    timeprecision 1ps;
    int lowCnt = 0, holdLeft = 0, presWait = 0, presLeft = 0;
    logic lastLevel = 1'b1;
    initial slvLow = 1'b0;
    always @(posedge clk) begin
        if (lastLevel && !lineLevel && !slvLow) begin
            holdLeft = readZero ? int'(holdCyc) : 0;
        end
        if (!lineLevel) lowCnt++;
        if (!lastLevel && lineLevel) begin
            if (lowCnt >= 50 && presEn) presWait = 25;
            lowCnt = 0;
        end
        if (presWait > 0) begin
            presWait--;
            if (presWait == 0) presLeft = 20;
        end else if (presLeft > 0) presLeft--;
        if (holdLeft > 0) holdLeft--;
        lastLevel = lineLevel;
        slvLow <= forceLow || holdLeft > 0 || presLeft > 0;
    end
endmodule : swsp_slave_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the single-wire slot and pullup timer.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, st;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, lineOut, lineOe, apuOe, weakPuOn, slvLow, lineLevel;
    logic presEn = 1'b1, readZero = 1'b0, forceLow = 1'b0, od, multi, apuEn, b1, b2;
    logic [7:0] holdCyc = 8'h1E;
    logic oeP = 1'b0, lvP = 1'b1, apuP = 1'b0;
    int mismatches = 0, total_checks = 0, seed = 32'h491f, cyc = 0, oeCnt = 0, riseC = 0, oeRiseC = 0;
    int apuRises = 0, op1, op2;
    int lenQ[$], gapQ[$], slotQ[$];
    int tm[18] = '{10, 40, 8, 25, 80, 100, 150, 20, 6, 4, 12, 3, 8, 30, 60, 100, 8, 3};
    assign lineLevel = !(lineOe || slvLow);
    always #5 clk = ~clk;
    swsp_slot_timer i_swsp_slot_timer (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .lineIn(lineLevel), .lineOut(lineOut), .lineOe(lineOe), .apuThrIn(lineLevel), .apuOe(apuOe),
        .weakPuOn(weakPuOn));
    swsp_slave_model i_swsp_slave_model (.clk(clk), .lineLevel(lineLevel), .presEn(presEn),
        .readZero(readZero), .forceLow(forceLow), .holdCyc(holdCyc), .slvLow(slvLow));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Counts: %0d mismatches in %0d checks", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        forever begin
            @(negedge clk);
            if (avs_waitrequest === 1'b0 || n > 3000) break;
            n++;
            @(posedge clk);
        end
        q = avs_readdata;
        chk("busAnswer", 1, n <= 3000);
        @(posedge clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic cmd(input int op, input logic b);
        bus(swsp_pkg::A_CMD, 1'b1, 32'(op) | (32'(b) << 2), 4'hF);
    endtask : cmd
    task automatic waitIdle();
        int n;
        n = 0;
        st = 32'h1;
        while (st[swsp_pkg::S_BUSY] !== 1'b0 && n < 2000) begin
            bus(swsp_pkg::A_STAT, 1'b0, 32'h0, 4'hF);
            st = q;
            n++;
        end
        chk("idleWait", 1, n < 2000);
        @(negedge clk);
    endtask : waitIdle
    function automatic int lowOf(input logic o, input int op, input logic b);
        return op == 0 ? tm[int'(o) * 9 + 5] : (op == 1 && !b) ? tm[int'(o) * 9 + 1] : tm[int'(o) * 9];
    endfunction : lowOf
    function automatic int recOf(input logic o, input int op, input logic b, input logic m);
        int x;
        x = int'(o) * 9;
        return tm[x + 2] + ((op == 2 || b) ? tm[x + 1] - tm[x] : 0) + (m ? tm[x + 8] : 0);
    endfunction : recOf
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (lineOe && !oeP) begin
            gapQ.push_back(cyc - riseC);
            slotQ.push_back(cyc - oeRiseC);
            oeRiseC = cyc;
        end
        if (lineOe) oeCnt++;
        if (!lineOe && oeP) begin
            lenQ.push_back(oeCnt);
            oeCnt = 0;
        end
        if (lineLevel && !lvP) riseC = cyc;
        if (apuOe && !apuP) apuRises++;
        if (apuOe && lineOe) chk("apuWhileLow", 0, 1);
        if (rst_n && weakPuOn === lineOe) chk("weakPuVsDrive", 1, 0);
        if (lineOe && lineOut !== 1'b0) chk("lineOutLow", 0, lineOut);
        if (!lineLevel && lvP && !lineOe && !slvLow) chk("strayFall", 0, 1);
        oeP = lineOe;
        lvP = lineLevel;
        apuP = apuOe;
    end
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("weakPuRst", 1, {weakPuOn, lineOe, apuOe} == 3'b100);
        bus(swsp_pkg::A_CTRL, 1'b0, 32'h0, 4'hF);
        chk("ctrlRst", 0, q);
        bus(8'h40, 1'b0, 32'h0, 4'hF);
        chk("timerRst", 32'h320, q);
        bus(8'hFC, 1'b0, 32'h0, 4'hF);
        chk("unmapped", 0, q);
        for (int i = 0; i < 18; i++) bus(8'h40 + 8'(4 * i), 1'b1, {16'($random(seed)), 16'(tm[i])}, 4'hF);
        bus(8'h40, 1'b1, 32'h7, 4'h1);
        bus(8'h40, 1'b0, 32'h0, 4'hF);
        chk("timerBack", 32'(tm[0]), q);
        for (int k = 0; k < 20; k++) begin
            od = 1'($random(seed));
            multi = 1'($random(seed));
            apuEn = 1'($random(seed));
            b1 = 1'($random(seed));
            b2 = 1'($random(seed));
            op1 = k < 2 ? 2 : 1 + ($random(seed) & 1);
            op2 = k < 2 ? 2 : 1 + ($random(seed) & 1);
            readZero <= 1'($random(seed));
            holdCyc <= od ? 8'h0A : 8'h1E;
            bus(swsp_pkg::A_CTRL, 1'b1, {28'h0, multi, 1'b0, apuEn, od}, 4'hF);
            lenQ.delete();
            apuRises = 0;
            cmd(op1, b1);
            cmd(op2, b2);
            waitIdle();
            chk("slotCount", 2, lenQ.size());
            chk("lowFirst", lowOf(od, op1, b1), lenQ[0]);
            chk("lowSecond", lowOf(od, op2, b2), lenQ[1]);
            chk("recovery", 1, gapQ[gapQ.size() - 1] >= recOf(od, op1, b1, multi) + 2);
            if (op1 == 2) chk("slotLen", 1, slotQ[slotQ.size() - 1] >= tm[int'(od) * 9 + 4]);
            if (op2 == 2) chk("readBit", !readZero, st[swsp_pkg::S_RBIT]);
            chk("apuRises", apuEn ? 2 : 0, apuRises);
            chk("apuIdle", 0, apuOe);
        end
        for (int k = 0; k < 4; k++) begin
            od = k[0];
            presEn <= k[1];
            bus(swsp_pkg::A_CTRL, 1'b1, 32'h2 | 32'(od), 4'hF);
            lenQ.delete();
            apuRises = 0;
            cmd(0, 1'b0);
            waitIdle();
            chk("rstLow", tm[int'(od) * 9 + 5], lenQ[0]);
            chk("presence", k[1], st[swsp_pkg::S_PRES]);
            chk("rstApu", k[1] ? 2 : 1, apuRises);
        end
        presEn <= 1'b1;
        bus(swsp_pkg::A_CTRL, 1'b1, 32'h6, 4'hF);
        cmd(1, 1'b1);
        waitIdle();
        chk("spuOn", 1, {apuOe, st[swsp_pkg::S_SPU]} == 2'b11);
        repeat (100) @(posedge clk);
        chk("spuHold", 1, apuOe);
        cmd(0, 1'b0);
        @(posedge clk);
        @(negedge clk);
        chk("spuEndCmd", 0, apuOe);
        waitIdle();
        bus(swsp_pkg::A_CTRL, 1'b0, 32'h0, 4'hF);
        chk("spuAutoClear", 2, q);
        bus(swsp_pkg::A_CTRL, 1'b1, 32'h6, 4'hF);
        cmd(2, 1'b0);
        waitIdle();
        chk("spuRead", 1, apuOe);
        bus(swsp_pkg::A_CTRL, 1'b1, 32'h2, 4'hF);
        @(posedge clk);
        @(negedge clk);
        chk("spuOff", 0, apuOe);
        apuRises = 0;
        cmd(1, 1'b1);
        forceLow <= 1'b1;
        waitIdle();
        chk("short", 1, st[swsp_pkg::S_SHORT]);
        forceLow <= 1'b0;
        repeat (80) @(posedge clk);
        chk("noApuAfterShort", 0, apuRises);
        lenQ.delete();
        cmd(3, 1'b0);
        repeat (5) @(posedge clk);
        chk("opIgnored", 0, lenQ.size() + int'(lineOe));
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
